// ==== rtl/pmta_regs.vh ====
`ifndef PMTA_REGS_VH
`define PMTA_REGS_VH
// register byte addresses on the bus
`define PMTA_ADDR_CTRL 8'h00
`define PMTA_ADDR_PTR 8'h04
`define PMTA_ADDR_LATCH 8'h08
`define PMTA_ADDR_STATUS 8'h0C
// control fields
`define PMTA_CTRL_LWE_BIT 0
// status fields
`define PMTA_ST_BUSY_BIT 0
`define PMTA_ST_LWE_BIT 1
`define PMTA_ST_FLAG_BIT 2
// pointer width and update span
`define PMTA_PTR_W 22
`define PMTA_PTR_UPD_W 21
// reset values
`define PMTA_PTR_RST 22'h000000
`define PMTA_LATCH_RST 8'h00
// table access modes
`define PMTA_MODE_KEEP 2'h0
`define PMTA_MODE_POSTINC 2'h1
`define PMTA_MODE_POSTDEC 2'h2
`define PMTA_MODE_PREINC 2'h3
// resume actions after a long write ends
`define PMTA_RES_NEXT 2'h0
`define PMTA_RES_LOW 2'h1
`define PMTA_RES_HIGH 2'h2
// axi responses
`define PMTA_RESP_OKAY 2'h0
`define PMTA_RESP_SLVERR 2'h2
`endif

// ==== rtl/pmta_table_access.v ====
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "pmta_regs.vh"
// Operation
// - pointer keep, post-inc, post-dec or pre-inc
// - table read loads one addressed byte
// - writes handled as two-byte blocks
// - even write copies latch to holding
// - holding register has no bus address
// - odd write starts a long write
// - latch high byte, holding low byte
// - long write halts instruction execution
// - long write needs volt, enable, odd
// - enable clear means short write only
// - enable bit set-only until reset
// - long write ends only by reset/interrupt
// - enabled flagged source stops programming
// - terminating interrupt flag stays set
// - disabled source never stops programming
// - enabled source waits for its flag
// - resume next for listed enable cases
// - low vector for low-enable, low source
// - high vector for high-enable, high source
// - pointer 22 bits, update low 21
// - table latch is eight bits
module pmta_table_access (
  input wire clock,
  input wire rst,
  input wire clk_en,
  // core table instruction port
  input wire tbl_rd_req,
  input wire tbl_wr_req,
  input wire [1:0] tbl_mode,
  input wire reset_progvolt_pin,
  // interrupt sources seen by the core
  input wire [7:0] irq_enable,
  input wire [7:0] irq_flag,
  input wire [7:0] irq_high_prio,
  input wire global_high_irq_enable,
  input wire global_low_irq_enable,
  // program memory port
  output reg [20:0] pm_addr,
  output reg pm_rd_en,
  input wire [7:0] pm_rd_data,
  output reg pm_prog_en,
  output reg [15:0] pm_prog_data,
  // core control outputs
  output reg core_halt,
  output reg done_pulse,
  output reg [1:0] resume_action,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // engine states
  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_PROG = 2'h2;

  // engine state; the holding byte lives only here, never on the bus
  reg [1:0] state_q;
  reg [`PMTA_PTR_W-1:0] table_pointer;
  reg [7:0] table_latch;
  reg [7:0] hold_q;
  reg long_write_enable;
  reg [1:0] mode_q;
  // write channel capture so address and data may arrive in any order
  reg aw_seen_q;
  reg w_seen_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  // read decode result, registered into rdata by the bus process
  reg [31:0] rd_d;
  reg rd_ok;

  // only the low 21 bits move; bit 21 is kept as written
  function [`PMTA_PTR_W-1:0] ptr_step;
    input [`PMTA_PTR_W-1:0] p;
    input inc;
    begin
      if (inc) begin
        ptr_step = {p[21], p[20:0] + 21'h000001};
      end else begin
        ptr_step = {p[21], p[20:0] - 21'h000001};
      end
    end
  endfunction

  // address used by the access, pre-increment applied first
  function [`PMTA_PTR_W-1:0] ptr_access;
    input [`PMTA_PTR_W-1:0] p;
    input [1:0] m;
    begin
      if (m == `PMTA_MODE_PREINC) begin
        ptr_access = ptr_step(p, 1'b1);
      end else begin
        ptr_access = p;
      end
    end
  endfunction

  // pointer value after the access completes
  function [`PMTA_PTR_W-1:0] ptr_after;
    input [`PMTA_PTR_W-1:0] p;
    input [1:0] m;
    begin
      case (m)
        `PMTA_MODE_POSTINC: ptr_after = ptr_step(p, 1'b1);
        `PMTA_MODE_POSTDEC: ptr_after = ptr_step(p, 1'b0);
        `PMTA_MODE_PREINC: ptr_after = ptr_step(p, 1'b1);
        default: ptr_after = p;
      endcase
    end
  endfunction

  // registers that accept a bus write; status is read-only and the
  // holding byte has no address at all
  function wr_mapped;
    input [7:0] a;
    begin
      wr_mapped = (a == `PMTA_ADDR_CTRL) || (a == `PMTA_ADDR_PTR) ||
        (a == `PMTA_ADDR_LATCH);
    end
  endfunction

  // resume decision once a long write is ended by a source; a vector is
  // taken only when exactly one global enable is set and it matches the
  // priority of the terminating source, otherwise the core simply goes
  // on with the next instruction
  function [1:0] resume_pick;
    input gh;
    input gl;
    input hi;
    begin
      if (gl && !gh && !hi) begin
        resume_pick = `PMTA_RES_LOW;
      end else if (gh && !gl && hi) begin
        resume_pick = `PMTA_RES_HIGH;
      end else begin
        resume_pick = `PMTA_RES_NEXT;
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // per-source termination decode; priority and the global enables
  // never gate the stop, they only steer where the core resumes
  wire [7:0] src_stop;
  wire [7:0] src_high;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_src
      // a disabled source is ignored even with its flag up
      assign src_stop[gi] = irq_enable[gi] & irq_flag[gi];
      // an enabled source with a low flag keeps the write going
      assign src_high[gi] = src_stop[gi] & irq_high_prio[gi];
    end
  endgenerate

  wire [`PMTA_PTR_W-1:0] acc_ptr = ptr_access(table_pointer, tbl_mode);
  // the odd byte starts programming only with all three conditions met
  wire long_ok = reset_progvolt_pin & long_write_enable & acc_ptr[0];
  wire [7:0] term_vec = src_stop;
  wire term_hit = |term_vec;
  wire term_high = |src_high;

  // register map: control (set-only enable), pointer, latch and a
  // read-only status word; anything else answers with a slave error
  // bus write strobes for the three writable registers
  wire aw_now = aw_seen_q | s_axi_awvalid;
  wire w_now = w_seen_q | s_axi_wvalid;
  wire [7:0] wa = aw_seen_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wd = w_seen_q ? w_data_q : s_axi_wdata;
  wire [3:0] ws = w_seen_q ? w_strb_q : s_axi_wstrb;
  wire wr_fire = aw_now & w_now & ~s_axi_bvalid;
  wire wr_ctrl = wr_fire & (wa == `PMTA_ADDR_CTRL) & ws[0];
  wire wr_ptr = wr_fire & (wa == `PMTA_ADDR_PTR);
  wire wr_lat = wr_fire & (wa == `PMTA_ADDR_LATCH) & ws[0];
  wire idle = (state_q == ST_IDLE);

  //////////////////////////////////////////////////////////////////////
  // table instruction engine
  // a table read takes two cycles: strobe and address out, then the
  // byte is captured and the core released
  // a short write finishes in the cycle after the request
  // a long write holds the core until an enabled source flags; there
  // is deliberately no timer, so a bad setup halts the core until reset
  // requests that arrive while busy are dropped, the core is halted then
  always @(posedge clock) begin
    if (rst) begin
      state_q <= ST_IDLE;
      table_pointer <= `PMTA_PTR_RST;
      table_latch <= `PMTA_LATCH_RST;
      hold_q <= 8'h00;
      long_write_enable <= 1'b0;
      mode_q <= `PMTA_MODE_KEEP;
      pm_addr <= 21'h000000;
      pm_rd_en <= 1'b0;
      pm_prog_en <= 1'b0;
      pm_prog_data <= 16'h0000;
      core_halt <= 1'b0;
      done_pulse <= 1'b0;
      resume_action <= `PMTA_RES_NEXT;
    end else if (clk_en) begin
      done_pulse <= 1'b0;
      pm_rd_en <= 1'b0;
      // set-only; only reset clears it
      if (wr_ctrl && wd[`PMTA_CTRL_LWE_BIT]) begin
        long_write_enable <= 1'b1;
      end
      // latch and pointer writes land only while idle so a long write sees stable data
      if (idle && wr_lat) begin
        table_latch <= wd[7:0];
      end
      // the pointer takes each byte lane on its own strobe
      if (idle && wr_ptr) begin
        if (ws[0]) table_pointer[7:0] <= wd[7:0];
        if (ws[1]) table_pointer[15:8] <= wd[15:8];
        if (ws[2]) table_pointer[21:16] <= wd[21:16];
      end
      case (state_q)
        ST_IDLE: begin
          // a read wins when both requests arrive together
          if (tbl_rd_req) begin
            pm_addr <= acc_ptr[20:0];
            pm_rd_en <= 1'b1;
            mode_q <= tbl_mode;
            core_halt <= 1'b1;
            state_q <= ST_READ;
          end else if (tbl_wr_req) begin
            // pointer moves at once; the access itself uses acc_ptr
            table_pointer <= ptr_after(table_pointer, tbl_mode);
            if (long_ok) begin
              // one word per block, low byte from holding
              pm_addr <= {acc_ptr[20:1], 1'b0};
              pm_prog_data <= {table_latch, hold_q};
              pm_prog_en <= 1'b1;
              core_halt <= 1'b1;
              state_q <= ST_PROG;
            end else if (!acc_ptr[0]) begin
              hold_q <= table_latch;
              done_pulse <= 1'b1;
            end else begin
              done_pulse <= 1'b1;
            end
          end
        end
        ST_READ: begin
          // memory answers one cycle after the strobe
          table_latch <= pm_rd_data;
          table_pointer <= ptr_after(table_pointer, mode_q);
          core_halt <= 1'b0;
          done_pulse <= 1'b1;
          state_q <= ST_IDLE;
        end
        ST_PROG: begin
          // no timer: only an enabled flagged source ends it
          if (term_hit) begin
            pm_prog_en <= 1'b0;
            core_halt <= 1'b0;
            done_pulse <= 1'b1;
            state_q <= ST_IDLE;
            resume_action <= resume_pick(global_high_irq_enable, global_low_irq_enable, term_high);
          end else begin
            pm_prog_en <= 1'b1;
          end
        end
        // an unused code falls back to idle
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read data decode; holding register deliberately absent
  // the status flag mirrors live source state; flags are never cleared here
  always @* begin
    rd_d = 32'h00000000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `PMTA_ADDR_CTRL: rd_d[`PMTA_CTRL_LWE_BIT] = long_write_enable;
      `PMTA_ADDR_PTR: rd_d[21:0] = table_pointer;
      `PMTA_ADDR_LATCH: rd_d[7:0] = table_latch;
      `PMTA_ADDR_STATUS: begin
        rd_d[`PMTA_ST_BUSY_BIT] = ~idle;
        rd_d[`PMTA_ST_LWE_BIT] = long_write_enable;
        rd_d[`PMTA_ST_FLAG_BIT] = term_hit;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // axi4-lite handshakes; address and data accepted in either order
  always @(posedge clock) begin
    if (rst) begin
      aw_seen_q <= 1'b0;
      w_seen_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PMTA_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PMTA_RESP_OKAY;
    end else if (clk_en) begin
      // ready strobes last one cycle
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      if (s_axi_awvalid && !aw_seen_q && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        aw_seen_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_seen_q && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
        w_seen_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      // respond only once both halves are held; a refused address still answers
      if (aw_seen_q && w_seen_q && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        aw_seen_q <= 1'b0;
        w_seen_q <= 1'b0;
        if (wr_mapped(aw_addr_q)) begin
          s_axi_bresp <= `PMTA_RESP_OKAY;
        end else begin
          s_axi_bresp <= `PMTA_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // read data is captured with arready so it stands until rready
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_d;
        s_axi_rresp <= rd_ok ? `PMTA_RESP_OKAY : `PMTA_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // pmta_table_access
`default_nettype wire

// ==== test/pmta_props.sv ====
`timescale 1ns/1ns
`default_nettype none
// port-level watch of the table access block
module pmta_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic tbl_rd_req,
  input wire logic tbl_wr_req,
  input wire logic reset_progvolt_pin,
  input wire logic [7:0] irq_enable,
  input wire logic [7:0] irq_flag,
  input wire logic [7:0] irq_high_prio,
  input wire logic global_high_irq_enable,
  input wire logic global_low_irq_enable,
  input wire logic [20:0] pm_addr,
  input wire logic pm_rd_en,
  input wire logic pm_prog_en,
  input wire logic [15:0] pm_prog_data,
  input wire logic core_halt,
  input wire logic done_pulse,
  input wire logic [1:0] resume_action
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // an enabled source with its flag up ends programming
  wire logic stop_w = |(irq_enable & irq_flag);
  ////////////////////////////////////////
  read_issue_a: assert property (tbl_rd_req && !core_halt && !done_pulse |=> pm_rd_en)
    else $error("table read not issued");
  read_end_a: assert property (pm_rd_en |=> done_pulse && !core_halt)
    else $error("table read did not finish");
  prog_halts_a: assert property (pm_prog_en |-> core_halt)
    else $error("programming without halt");
  prog_cause_a: assert property ($rose(pm_prog_en) |-> $past(tbl_wr_req && reset_progvolt_pin))
    else $error("programming without cause");
  prog_word_a: assert property (pm_prog_en |-> !pm_addr[0])
    else $error("programming address not a block");
  prog_holds_a: assert property (pm_prog_en && !stop_w |=> pm_prog_en)
    else $error("programming stopped early");
  prog_stops_a: assert property (pm_prog_en && stop_w |-> ##[1:2] $fell(pm_prog_en))
    else $error("programming did not stop");
  prog_steady_a: assert property (pm_prog_en && $past(pm_prog_en) |-> $stable({pm_prog_data, pm_addr}))
    else $error("programmed word moved");
  next_instr_a: assert property ($fell(pm_prog_en) && !global_high_irq_enable
    && !global_low_irq_enable |-> resume_action == 2'h0)
    else $error("resume not next instruction");
endmodule // pmta_props
`default_nettype wire

// ==== test/pmta_mem_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// program memory stand-in; read data is only good while the strobe is up
module pmta_mem_model (
  input wire logic clock,
  input wire logic pm_rd_en,
  input wire logic [20:0] pm_addr,
  input wire logic pm_prog_en,
  input wire logic [15:0] pm_prog_data,
  output logic [7:0] pm_rd_data,
  output logic [15:0] word_q,
  output logic [20:0] waddr_q,
  output int prog_count
);
  logic [7:0] junk_q = 8'h3C;
  logic prog_q = 1'h0;
  assign pm_rd_data = pm_rd_en ? pm_addr[7:0] ^ pm_addr[15:8] ^ pm_addr[20:13] : junk_q;
  initial prog_count = 0;
  // junk flips every cycle so a late sample never matches by luck
  always @(posedge clock) begin
    junk_q <= ~junk_q;
    prog_q <= pm_prog_en;
    if (pm_prog_en && !prog_q) begin
      word_q <= pm_prog_data;
      waddr_q <= pm_addr;
      prog_count <= prog_count + 1;
    end
  end
endmodule // pmta_mem_model
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clock = 1'h0, rst = 1'h1, clk_en = 1'h1, tbl_rd_req = 1'h0, tbl_wr_req = 1'h0;
  logic reset_progvolt_pin = 1'h0, global_high_irq_enable = 1'h0, global_low_irq_enable = 1'h0;
  logic [1:0] tbl_mode = 2'h0, resume_action, s_axi_bresp, s_axi_rresp;
  logic [7:0] irq_enable = 8'h0, irq_flag = 8'h0, irq_high_prio = 8'h0, pm_rd_data;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, pm_rd_en, pm_prog_en, core_halt, done_pulse;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [20:0] pm_addr, waddr_q, a;
  logic [15:0] pm_prog_data, word_q;
  logic [21:0] p;
  logic [4:0] c;
  logic [4:0] cfg [5] = '{5'h04, 5'h0C, 5'h10, 5'h09, 5'h16}; // high, low, prio, action
  logic [33:0] q [$];
  int fail_count = 0, tests_run = 0, prog_count, seed = 79466;
  pmta_table_access dut_u (.*);
  pmta_mem_model mem_u (.*);
  initial forever #25 clock = ~clock;
  ////////////////////////////////////////
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
    q.push_back({r, 32'h0});
    @(posedge clock);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [33:0] e);
    q.push_back(e);
    @(posedge clock);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask
  // one instruction pulse, then wait for completion unless wt is clear
  task automatic tbl(input logic r, input logic [1:0] m, input logic wt = 1'h1);
    @(posedge clock);
    tbl_rd_req <= r;
    tbl_wr_req <= !r;
    tbl_mode <= m;
    @(posedge clock);
    tbl_rd_req <= 1'h0;
    tbl_wr_req <= 1'h0;
    if (wt) begin
      do @(posedge clock); while (!done_pulse);
    end
  endtask
  ////////////////////////////////////////
  // bus answers are compared against the oldest note
  always @(posedge clock) begin
    if (q.size() > 0 && ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready))) begin
      chk({6'h0, s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0}}, {6'h0, q.pop_front()});
    end
  end
  initial begin
    #1000000;
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'h0;
    rd(8'h04, 34'h0);
    rd(8'h08, 34'h0);
    rd(8'h10, 34'h200000000);
    wr(8'h14, 32'h1, 2'h2);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      rnd = $random(seed);
      p = (m == 1) ? 22'h3FFFFF : rnd[21:0];
      wr(8'h04, {10'h0, p}, 2'h0);
      tbl(1'h1, m[1:0]);
      a = (m == 3) ? p[20:0] + 21'h1 : p[20:0];
      rd(8'h08, {26'h0, a[7:0] ^ a[15:8] ^ a[20:13]});
      a = (m == 2) ? p[20:0] - 21'h1 : (m == 0) ? p[20:0] : p[20:0] + 21'h1;
      rd(8'h04, {12'h0, p[21], a});
    end
    $display("test modes done");
    reset_progvolt_pin <= 1'h1;
    wr(8'h04, 32'h41, 2'h0);
    tbl(1'h0, 2'h0);
    chk(40'(prog_count), 40'h0);
    wr(8'h00, 32'h1, 2'h0);
    wr(8'h00, 32'h0, 2'h0);
    rd(8'h0C, 34'h2);
    reset_progvolt_pin <= 1'h0;
    tbl(1'h0, 2'h0);
    chk(40'(prog_count), 40'h0);
    $display("test short writes done");
    reset_progvolt_pin <= 1'h1;
    irq_enable <= 8'h01;
    irq_flag <= 8'h02;
    for (int i = 0; i < 5; i++) begin
      c = cfg[i];
      global_high_irq_enable <= c[4];
      global_low_irq_enable <= c[3];
      irq_high_prio <= {7'h0, c[2]};
      rnd = $random(seed);
      p = {1'h0, rnd[20:1], 1'h0};
      wr(8'h04, {10'h0, p}, 2'h0);
      wr(8'h08, {24'h0, rnd[31:24]}, 2'h0);
      tbl(1'h0, 2'h1);
      wr(8'h08, {24'h0, rnd[23:16]}, 2'h0);
      tbl(1'h0, 2'h0, 1'h0);
      repeat (20) @(posedge clock);
      rd(8'h0C, 34'h3);
      chk({3'h0, word_q, waddr_q}, {3'h0, rnd[23:16], rnd[31:24], p[20:0]});
      irq_flag <= 8'h03;
      do @(posedge clock); while (!done_pulse);
      chk({38'h0, resume_action}, {38'h0, c[1:0]});
      chk({3'h0, word_q, waddr_q}, {3'h0, rnd[23:16], rnd[31:24], p[20:0]});
      rd(8'h0C, 34'h6);
      irq_flag <= 8'h02;
    end
    $display("test long writes done");
    rst <= 1'h1;
    @(posedge clock);
    rst <= 1'h0;
    rd(8'h0C, 34'h0);
    $display("test second reset done");
    end_sim();
  end
endmodule // testbench
bind pmta_table_access pmta_props props_u (.*);
`default_nettype wire
